/* rtl/pin_cfg_map.svh */
/*
 * offsets, index codes, reset values and widths of the per-port pin configuration block.
 * assumes inclusion by bare name from rtl/; definitions only.
 */
`ifndef PIN_CFG_MAP_SVH
`define PIN_CFG_MAP_SVH

// ----------------------------------------------------------------
// register offsets inside one port's four-byte group
// ----------------------------------------------------------------
`define OFS_INDEX_SELECT   2'h0
`define OFS_CONFIG_WINDOW  2'h1

// ----------------------------------------------------------------
// subregister index codes held in the index register
// ----------------------------------------------------------------
`define IDX_NONE           8'h00
`define IDX_DIRECTION      8'h01
`define IDX_ALT_ENABLE     8'h02
`define IDX_OPEN_DRAIN     8'h03
`define IDX_HIGH_DRIVE     8'h04
`define IDX_WAKE_SOURCE    8'h05
`define IDX_ALT_SEL_LOW    8'h07
`define IDX_ALT_SEL_HIGH   8'h08

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_INDEX          8'h00
`define RST_DIRECTION      8'hFF
`define RST_ALT_EN_ABC     8'h00
`define RST_ALT_EN_D       8'h01
`define RST_OPEN_DRAIN     8'h00
`define RST_HIGH_DRIVE     8'h00
`define RST_WAKE_SOURCE    8'h00
`define RST_ALT_SEL        8'h00

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define PIN_COUNT          8
`define ALT_FUNC_COUNT     4

`endif

/* rtl/pin_cfg_pkg.sv */
/*
 * types shared by the pin configuration block.
 * assumes pin_cfg_map.svh is on the include path.
 */
package pin_cfg_pkg;
	// which configuration subregister the index register points at
	typedef enum logic [6:0] {
		SEL_NONE   = 7'b000_0001,
		SEL_DIR    = 7'b000_0010,
		SEL_ALTEN  = 7'b000_0100,
		SEL_ODRAIN = 7'b000_1000,
		SEL_HDRIVE = 7'b001_0000,
		SEL_WAKE   = 7'b010_0000,
		SEL_ALTSEL = 7'b100_0000
	} window_sel_e;
endpackage

/* rtl/pin_wake_detect.sv */
/*
 * stop-mode wake detector: synchronises the pins and pulses on any enabled edge.
 * assumes pins are asynchronous to mclk_i and stop_mode_i comes from mclk_i logic.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_wake_detect #(
	parameter int WIDTH = 8
) (
	input  wire logic             mclk_i,       // system clock
	input  wire logic             nrst_i,       // synchronous reset, low
	input  wire logic [WIDTH-1:0] pin_i,        // raw pin levels
	input  wire logic [WIDTH-1:0] wake_en_i,    // per-pin wake enable
	input  wire logic             stop_mode_i,  // chip in stop mode
	output logic      [WIDTH-1:0] pin_sync_o,   // synchronised pin levels
	output logic                  wake_o        // recovery request, registered
);
	logic [WIDTH-1:0] meta_q, meta_d;
	logic [WIDTH-1:0] sync_q, sync_d;
	logic [WIDTH-1:0] prev_q, prev_d;
	logic             wake_q, wake_d;

	// next values: second stage reads first only; edges from second stage on
	always_comb begin
		meta_d = pin_i;
		sync_d = meta_q;
		prev_d = sync_q;
		wake_d = stop_mode_i && |((sync_q ^ prev_q) & wake_en_i);
	end

	// registers
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
			wake_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
			wake_q <= wake_d;
		end
	end

	assign pin_sync_o = sync_q;
	assign wake_o     = wake_q;

	AST_WAKE_ON_EDGE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(stop_mode_i && |((sync_q ^ prev_q) & wake_en_i)) |=> wake_q)
		else $error("enabled edge in stop mode gave no wake");
	AST_NO_WAKE_MASKED: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(!(|((sync_q ^ prev_q) & wake_en_i))) |=> !wake_q)
		else $error("wake without an enabled edge");
endmodule

`default_nettype wire

/* rtl/gpio_pin_config.sv */
/*
 * per-port pin configuration: index register, config window and the
 * alt-enable, open-drain, high-drive and wake-source subregisters, plus
 * direction and alt-select which steer the pin driver.
 * assumes a byte register port on mclk_i with one-cycle write strobe and
 * combinational-address read data registered next cycle; pins external.
 */
// Notes on behaviour
// - index 02H reaches alt-enable subregister
// - alt-enable 0 means GPIO with direction bit
// - alt-enable 1 hands pin to selected function
// - alt-enable resets 00H, port D 01H
// - index 03H reaches open-drain, reset zero
// - open-drain bit 1 never drives high
// - open-drain 0 drives both levels
// - index 04H reaches high-drive, reset zero
// - high-drive bit sets pin current control
// - index 05H reaches wake-source, reset zero
// - enabled pin edge in stop starts recovery
// - disabled pin edges never start recovery
// - eight bits, bit n controls pin n
// - index register picks window subregister
// - index 00H selects nothing, writes ignored
// - direction 0 drives output, 1 tristates
`timescale 1ns/1ps
`default_nettype none
`include "pin_cfg_map.svh"

module gpio_pin_config
	import pin_cfg_pkg::*;
#(
	parameter bit   PORT_IS_D = 1'b0,              // selects port D alt-enable reset
	parameter int   PINS      = `PIN_COUNT         // pins per port
) (
	input  wire logic            mclk_i,           // 50 MHz system clock
	input  wire logic            nrst_i,           // synchronous reset, low
	input  wire logic [1:0]      reg_addr_i,       // register offset in port group
	input  wire logic            reg_wr_i,         // write strobe, one cycle
	input  wire logic            reg_rd_i,         // read strobe, one cycle
	input  wire logic [7:0]      reg_wdata_i,      // write data
	output logic      [7:0]      reg_rdata_o,      // read data, registered
	input  wire logic [PINS-1:0] out_data_i,       // GPIO output data
	input  wire logic [PINS-1:0] alt_out_i,        // alternate function output value
	input  wire logic [PINS-1:0] alt_oe_i,         // alternate function drive request
	input  wire logic            stop_mode_i,      // chip in stop mode
	input  wire logic [PINS-1:0] pin_i,            // pad input levels
	output logic      [PINS-1:0] pin_o,            // pad output value
	output logic      [PINS-1:0] pin_oe_o,         // pad driver enable, high drives
	output logic      [PINS-1:0] high_drive_o,     // high-current drive per pin
	output logic      [PINS-1:0] alt_owned_o,      // pin handed to alternate function
	output logic      [PINS*2-1:0] alt_sel_o,      // 2-bit function choice per pin
	output logic      [PINS-1:0] pin_in_o,         // synchronised pin levels
	output logic                 wake_o            // stop-mode recovery request
);
	localparam logic [7:0] ALT_EN_RST = PORT_IS_D ? `RST_ALT_EN_D : `RST_ALT_EN_ABC;

	// index decode, used by both the write and the read path
	function automatic window_sel_e decode_index(input logic [7:0] idx);
		unique case (idx)
			`IDX_DIRECTION:  decode_index = SEL_DIR;
			`IDX_ALT_ENABLE: decode_index = SEL_ALTEN;
			`IDX_OPEN_DRAIN: decode_index = SEL_ODRAIN;
			`IDX_HIGH_DRIVE: decode_index = SEL_HDRIVE;
			`IDX_WAKE_SOURCE: decode_index = SEL_WAKE;
			`IDX_ALT_SEL_LOW, `IDX_ALT_SEL_HIGH: decode_index = SEL_ALTSEL;
			default:         decode_index = SEL_NONE;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [7:0]      index_q,  index_d;
	logic [PINS-1:0] dir_q,    dir_d;
	logic [PINS-1:0] alten_q,  alten_d;
	logic [PINS-1:0] odrain_q, odrain_d;
	logic [PINS-1:0] hdrive_q, hdrive_d;
	logic [PINS-1:0] wake_q,   wake_d;
	logic [PINS-1:0] sel_lo_q, sel_lo_d;
	logic [PINS-1:0] sel_hi_q, sel_hi_d;
	logic [7:0]      rdata_q,  rdata_d;
	window_sel_e     sel;
	logic            win_wr;

	// window write steering and readback
	always_comb begin
		sel      = decode_index(index_q);
		win_wr   = reg_wr_i && (reg_addr_i == `OFS_CONFIG_WINDOW);
		index_d  = index_q;
		dir_d    = dir_q;
		alten_d  = alten_q;
		odrain_d = odrain_q;
		hdrive_d = hdrive_q;
		wake_d   = wake_q;
		sel_lo_d = sel_lo_q;
		sel_hi_d = sel_hi_q;
		rdata_d  = rdata_q;
		if (reg_wr_i && reg_addr_i == `OFS_INDEX_SELECT) begin
			index_d = reg_wdata_i;
		end
		if (win_wr) begin
			unique case (sel)
				SEL_DIR:    dir_d    = reg_wdata_i[PINS-1:0];
				SEL_ALTEN:  alten_d  = reg_wdata_i[PINS-1:0];
				SEL_ODRAIN: odrain_d = reg_wdata_i[PINS-1:0];
				SEL_HDRIVE: hdrive_d = reg_wdata_i[PINS-1:0];
				SEL_WAKE:   wake_d   = reg_wdata_i[PINS-1:0];
				SEL_ALTSEL: begin
					if (index_q == `IDX_ALT_SEL_LOW) begin
						sel_lo_d = reg_wdata_i[PINS-1:0];
					end else begin
						sel_hi_d = reg_wdata_i[PINS-1:0];
					end
				end
				SEL_NONE:   ;
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`OFS_INDEX_SELECT: rdata_d = index_q;
				`OFS_CONFIG_WINDOW: begin
					unique case (sel)
						SEL_DIR:    rdata_d = 8'(dir_q);
						SEL_ALTEN:  rdata_d = 8'(alten_q);
						SEL_ODRAIN: rdata_d = 8'(odrain_q);
						SEL_HDRIVE: rdata_d = 8'(hdrive_q);
						SEL_WAKE:   rdata_d = 8'(wake_q);
						SEL_ALTSEL: rdata_d = (index_q == `IDX_ALT_SEL_LOW) ? 8'(sel_lo_q) : 8'(sel_hi_q);
						SEL_NONE:   rdata_d = 8'h00;
					endcase
				end
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// register update
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			index_q  <= `RST_INDEX;
			dir_q    <= PINS'(`RST_DIRECTION);
			alten_q  <= PINS'(ALT_EN_RST);
			odrain_q <= PINS'(`RST_OPEN_DRAIN);
			hdrive_q <= PINS'(`RST_HIGH_DRIVE);
			wake_q   <= PINS'(`RST_WAKE_SOURCE);
			sel_lo_q <= PINS'(`RST_ALT_SEL);
			sel_hi_q <= PINS'(`RST_ALT_SEL);
			rdata_q  <= 8'h00;
		end else begin
			index_q  <= index_d;
			dir_q    <= dir_d;
			alten_q  <= alten_d;
			odrain_q <= odrain_d;
			hdrive_q <= hdrive_d;
			wake_q   <= wake_d;
			sel_lo_q <= sel_lo_d;
			sel_hi_q <= sel_hi_d;
			rdata_q  <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// pin driver
	// ----------------------------------------------------------------
	logic [PINS-1:0]   pout_q, pout_d;
	logic [PINS-1:0]   poe_q,  poe_d;
	logic [PINS-1:0]   hd_q,   hd_d;
	logic [PINS-1:0]   own_q,  own_d;
	logic [PINS*2-1:0] asel_q, asel_d;

	// driver source, then open-drain gating
	always_comb begin
		for (int n = 0; n < PINS; n++) begin
			logic drv;
			logic val;
			drv = alten_q[n] ? alt_oe_i[n] : !dir_q[n];
			val = alten_q[n] ? alt_out_i[n] : out_data_i[n];
			pout_d[n]      = odrain_q[n] ? 1'b0 : val;
			poe_d[n]       = drv && !(odrain_q[n] && val);
			asel_d[2*n+:2] = {sel_hi_q[n], sel_lo_q[n]};
		end
		hd_d  = hdrive_q;
		own_d = alten_q;
	end

	// driver registers
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			pout_q <= '0;
			poe_q  <= '0;
			hd_q   <= '0;
			own_q  <= '0;
			asel_q <= '0;
		end else begin
			pout_q <= pout_d;
			poe_q  <= poe_d;
			hd_q   <= hd_d;
			own_q  <= own_d;
			asel_q <= asel_d;
		end
	end

	// wake detection on synchronised pins
	pin_wake_detect #(
		.WIDTH       (PINS)
	) u_wake (
		.mclk_i      (mclk_i),
		.nrst_i      (nrst_i),
		.pin_i       (pin_i),
		.wake_en_i   (wake_q),
		.stop_mode_i (stop_mode_i),
		.pin_sync_o  (pin_in_o),
		.wake_o      (wake_o)
	);

	assign reg_rdata_o  = rdata_q;
	assign pin_o        = pout_q;
	assign pin_oe_o     = poe_q;
	assign high_drive_o = hd_q;
	assign alt_owned_o  = own_q;
	assign alt_sel_o    = asel_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_OD_NEVER_HIGH: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		$past(odrain_q) != '0 |-> ((pin_o & pin_oe_o & $past(odrain_q)) == '0))
		else $error("open-drain pin drove high");
	AST_GPIO_OUT: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(!alten_q[PINS-1] && !dir_q[PINS-1] && !odrain_q[PINS-1])
		|=> (pin_oe_o[PINS-1] && pin_o[PINS-1] == $past(out_data_i[PINS-1])))
		else $error("gpio output pin not driven");
	AST_GPIO_IN: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(!alten_q[0] && dir_q[0]) |=> !pin_oe_o[0])
		else $error("input pin driven");
	AST_ALT_DRIVE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(alten_q[0] && !odrain_q[0]) |=> (pin_oe_o[0] == $past(alt_oe_i[0]) && pin_o[0] == $past(alt_out_i[0])))
		else $error("alternate function not driving pin");
	AST_HIGH_DRIVE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		1'b1 |=> high_drive_o == $past(hdrive_q))
		else $error("high drive output wrong");
	AST_IDX0_NO_WRITE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(win_wr && index_q == `IDX_NONE) |=> $stable(alten_q) && $stable(odrain_q) && $stable(hdrive_q) && $stable(wake_q))
		else $error("write with index 00H changed a subregister");
	AST_ALTEN_WR: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(win_wr && index_q == `IDX_ALT_ENABLE) |=> alten_q == $past(reg_wdata_i[PINS-1:0]))
		else $error("alt enable write lost");
	AST_WAKE_RD: assert property (@(posedge mclk_i) disable iff (!nrst_i)
		(reg_rd_i && reg_addr_i == `OFS_CONFIG_WINDOW && index_q == `IDX_WAKE_SOURCE) |=> reg_rdata_o == 8'($past(wake_q)))
		else $error("wake source readback wrong");
	AST_RESET_VALS: assert property (@(posedge mclk_i)
		!nrst_i |=> (alten_q == ALT_EN_RST && odrain_q == '0 && hdrive_q == '0 && wake_q == '0))
		else $error("reset values wrong");
endmodule

`default_nettype wire

/* test/pad_partner.sv */
/*
 * pad and peripheral model: pull-up pads, an optional outside driver per pin,
 * and fixed peripheral outputs on pins 3..0.
 * assumes pin_o/pin_oe_o come from the port and ext_* from the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module pad_partner (
	input  wire logic [7:0] drv_val_i,  // port output value
	input  wire logic [7:0] drv_en_i,   // port drive enable
	input  wire logic [7:0] ext_en_i,   // outside driver on
	input  wire logic [7:0] ext_val_i,  // outside driver level
	output logic      [7:0] pad_o,      // resolved pad level
	output logic      [7:0] alt_out_o,  // peripheral output value
	output logic      [7:0] alt_oe_o    // peripheral drive request
);
	// port drive wins, then the outside driver, else the pull-up holds high
	always_comb begin
		pad_o = (drv_en_i & drv_val_i) | (~drv_en_i & ext_en_i & ext_val_i) | (~drv_en_i & ~ext_en_i);
	end

	// peripherals exist only on pins 3..0
	assign alt_out_o = 8'h06;
	assign alt_oe_o  = 8'h03;
endmodule

`default_nettype wire

/* test/gpio_pin_config_test.sv */
/*
 * self-checking bench for the pin configuration block.
 * assumes rtl/ on the include path and pad_partner compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_config_test;
	logic        mclk_i, nrst_i, reg_wr_i, reg_rd_i, stop_mode_i, wake_o;
	logic [1:0]  reg_addr_i;
	logic [7:0]  reg_wdata_i, reg_rdata_o, out_data_i, alt_out, alt_oe, pin_i, pin_o;
	logic [7:0]  pin_oe_o, high_drive_o, alt_owned_o, pin_in_o, ext_en, ext_val;
	logic [15:0] alt_sel_o;
	logic [7:0]  alt_owned_d;
	int          mismatches, total_checks;

	gpio_pin_config #(.PORT_IS_D(1'b0), .PINS(8)) u_dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .out_data_i(out_data_i), .alt_out_i(alt_out), .alt_oe_i(alt_oe),
		.stop_mode_i(stop_mode_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.high_drive_o(high_drive_o), .alt_owned_o(alt_owned_o), .alt_sel_o(alt_sel_o),
		.pin_in_o(pin_in_o), .wake_o(wake_o));

	pad_partner u_pads (.drv_val_i(pin_o), .drv_en_i(pin_oe_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
		.pad_o(pin_i), .alt_out_o(alt_out), .alt_oe_o(alt_oe));

	// port D copy: only its alt-enable reset value is judged
	gpio_pin_config #(.PORT_IS_D(1'b1), .PINS(8)) u_dut_d (.mclk_i(mclk_i), .nrst_i(nrst_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(), .out_data_i(out_data_i), .alt_out_i(alt_out), .alt_oe_i(alt_oe),
		.stop_mode_i(stop_mode_i), .pin_i(pin_i), .pin_o(), .pin_oe_o(), .high_drive_o(),
		.alt_owned_o(alt_owned_d), .alt_sel_o(), .pin_in_o(), .wake_o());

	// free-running 50 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end

	// compare and count, report a mismatch at once
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one register write: strobe held across one rising edge
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(negedge mclk_i);
		reg_addr_i = a; reg_wdata_i = d; reg_wr_i = 1'b1;
		@(negedge mclk_i);
		reg_wr_i = 1'b0;
	endtask

	// one register read, data judged half a cycle after the taking edge
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(negedge mclk_i);
		reg_addr_i = a; reg_rd_i = 1'b1;
		@(negedge mclk_i);
		reg_rd_i = 1'b0;
		check(reg_rdata_o, e);
	endtask

	// subregister access through index then window
	task automatic sub_wr(input logic [7:0] i, input logic [7:0] d);
		wr(2'h0, i);
		wr(2'h1, d);
	endtask

	task automatic sub_rd(input logic [7:0] i, input logic [7:0] e);
		wr(2'h0, i);
		rd(2'h1, e);
	endtask

	// reset values and an unmapped offset
	task automatic t_reset;
		for (int i = 2; i < 6; i++) sub_rd(i[7:0], 8'h00);
		check({alt_owned_o, high_drive_o}, 16'h0000);
		check(alt_owned_d, 8'h01);
		wr(2'h2, 8'hff);
		rd(2'h2, 8'h00);
		$display("test reset done");
	endtask

	// pin edges with and without stop mode and wake enable
	task automatic t_wake;
		logic [1:0] bit_n [4] = '{2'd1, 2'd0, 2'd0, 2'd0};
		logic       in_stop [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
		logic       seen;
		sub_wr(8'h05, 8'h01);
		for (int k = 0; k < 4; k++) begin
			@(negedge mclk_i);
			stop_mode_i = in_stop[k];
			ext_val[bit_n[k]] = ~ext_val[bit_n[k]];
			seen = 1'b0;
			repeat (8) begin
				@(negedge mclk_i);
				seen = seen | (wake_o === 1'b1);
			end
			check(seen, (k >= 2));
			check(pin_in_o, ext_val);
		end
		stop_mode_i = 1'b0;
		$display("test wake done");
	endtask

	// window writes land per index, index 00 guards, bits map to pins
	task automatic t_window;
		for (int i = 2; i < 6; i++) sub_wr(i[7:0], (i == 2) ? 8'h0a : 8'h5a ^ i[7:0]);
		wr(2'h0, 8'h00);
		wr(2'h1, 8'hff);
		rd(2'h1, 8'h00);
		for (int i = 2; i < 6; i++) sub_rd(i[7:0], (i == 2) ? 8'h0a : 8'h5a ^ i[7:0]);
		check({alt_owned_o, high_drive_o}, 16'h0a5e);
		sub_wr(8'h07, 8'h0a);
		sub_wr(8'h08, 8'h06);
		sub_rd(8'h07, 8'h0a);
		sub_rd(8'h08, 8'h06);
		for (int n = 0; n < 8; n++) check(alt_sel_o[2*n +: 2], {n == 1 || n == 2, n == 1 || n == 3});
		sub_wr(8'h05, 8'h00);
		$display("test window done");
	endtask

	// driver from gpio or peripheral, then open-drain gating
	task automatic t_drive;
		logic [7:0] od, val, en;
		sub_wr(8'h01, 8'h30);
		sub_wr(8'h02, 8'h0f);
		sub_wr(8'h04, 8'hc3);
		sub_rd(8'h01, 8'h30);
		for (int j = 0; j < 2; j++) begin
			od = j ? 8'h00 : 8'h83;
			sub_wr(8'h03, od);
			@(negedge mclk_i);
			out_data_i = j ? 8'h5a : 8'ha5;
			repeat (2) @(negedge mclk_i);
			val = (alt_out & 8'h0f) | (out_data_i & 8'hf0);
			en  = (alt_oe & 8'h0f) | (~8'h30 & 8'hf0);
			check(pin_o, val & ~od);
			check(pin_oe_o, en & ~(od & val));
			check({alt_owned_o, high_drive_o}, 16'h0fc3);
		end
		$display("test drive done");
	endtask

	// counts and verdict, then end of run
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// cut a hang short well past the expected run length
	initial begin
		repeat (5000) @(posedge mclk_i);
		mismatches++;
		print_verdict();
	end

	// main sequence
	initial begin
		mismatches = 0; total_checks = 0;
		nrst_i = 1'b0; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 2'h0; reg_wdata_i = 8'h00;
		out_data_i = 8'h00; stop_mode_i = 1'b0; ext_en = 8'hff; ext_val = 8'h00;
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
		nrst_i = 1'b1;
		t_reset();
		t_wake();
		t_window();
		t_drive();
		print_verdict();
	end
endmodule

`default_nettype wire
